// File: logic/dcrb_bank.sv
// Purpose: Device configuration register bank of a dual-PLL clock conditioner.
// Assumes: A serial engine delivers one decoded byte access per request pulse.
// Notes: Soft reset drives a one-cycle defaults pulse to the rest of the map.
`timescale 1ns/1ps
`default_nettype none
module dcrb_bank (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Power-up reset and non-volatile load
  input wire logic por_done,
  input wire logic nv_load,
  input wire dcrb_pkg::dcrb_config_type nv_config,
  // Register access from the serial engine
  input wire logic acc_req,
  input wire dcrb_pkg::dcrb_access_type acc,
  output logic [7:0] rdata,
  output logic rdata_valid,
  // Straps and interface select
  input wire logic address_strap_upper,
  input wire logic address_strap_lower,
  input wire logic interface_select_pin,
  // Serial data from and to the engine
  input wire logic sdo_bit,
  input wire logic sdo_drive,
  output logic sdi_bit,
  // Serial pins
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  output logic miso_out,
  output logic miso_oe,
  // Configuration outputs
  output logic serial_four_wire_select,
  output logic status_pin_level_select,
  output logic host_pin_level_select,
  output logic defaults_load
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // Access decode
  logic wr_ctl;
  logic wr_io;
  logic rd_req;
  logic soft_reset_req;

  // Soft reset sequencer
  dcrb_pkg::dcrb_soft_reset_state_type sr_state;
  dcrb_pkg::dcrb_soft_reset_state_type next_sr_state;
  logic next_defaults_load;

  // Configuration fields
  dcrb_pkg::dcrb_config_type cfg;
  dcrb_pkg::dcrb_config_type next_cfg;

  // Strap capture
  logic por_seen;
  logic next_por_seen;
  logic [1:0] strap_hold;
  logic [1:0] next_strap_hold;
  logic spi_mode;
  logic next_spi_mode;

  // Read path
  logic [7:0] next_rdata;
  logic next_rdata_valid;

  // Pin steering results and registered outputs
  logic mosi_out_c;
  logic mosi_oe_c;
  logic miso_out_c;
  logic miso_oe_c;
  logic sdi_bit_c;
  logic next_sdi_bit;
  logic next_mosi_out;
  logic next_mosi_oe;
  logic next_miso_out;
  logic next_miso_oe;
  logic next_serial_four_wire_select;
  logic next_status_pin_level_select;
  logic next_host_pin_level_select;

  // Decoded strobes; wr_en splits one request into a write or a read
  assign wr_ctl = acc_req && acc.wr_en && (acc.addr == dcrb_pkg::ADDR_DEVICE_CONTROL);
  assign wr_io = acc_req && acc.wr_en && (acc.addr == dcrb_pkg::ADDR_IO_VOLTAGE_SELECT);
  assign rd_req = acc_req && !acc.wr_en;
  assign soft_reset_req = wr_ctl && acc.wdata[dcrb_pkg::BIT_SOFT_REGISTER_RESET];

  // ----------------------------------------------------------------------
  // Soft reset sequencer
  // ----------------------------------------------------------------------
  // The reset bit is never stored, so it reads as zero right after the pulse
  // A request that lands while a pulse is in flight is dropped, not queued
  always_comb begin
    next_sr_state = sr_state;
    next_defaults_load = 1'b0;
    case (sr_state)
      dcrb_pkg::SR_IDLE: begin
        if (soft_reset_req) begin
          next_sr_state = dcrb_pkg::SR_PULSE;
        end
      end
      dcrb_pkg::SR_PULSE: begin
        next_defaults_load = 1'b1;
        next_sr_state = dcrb_pkg::SR_CLEAR;
      end
      dcrb_pkg::SR_CLEAR: begin
        next_sr_state = dcrb_pkg::SR_IDLE;
      end
      default: begin
        next_sr_state = dcrb_pkg::SR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sr_state <= dcrb_pkg::SR_IDLE;
      defaults_load <= 1'b0;
    end else begin
      sr_state <= next_sr_state;
      defaults_load <= next_defaults_load;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------------
  // Soft reset restores the level selects but keeps the wire mode at 0x00
  always_comb begin
    next_cfg = cfg;
    if (nv_load) begin
      next_cfg = nv_config;
    end else begin
      if (wr_ctl) begin
        next_cfg.serial_four_wire_select =
          acc.wdata[dcrb_pkg::BIT_SERIAL_FOUR_WIRE_SELECT];
      end
      if (wr_io) begin
        next_cfg.status_pin_level_select =
          acc.wdata[dcrb_pkg::BIT_STATUS_PIN_LEVEL_SELECT];
        next_cfg.host_pin_level_select =
          acc.wdata[dcrb_pkg::BIT_HOST_PIN_LEVEL_SELECT];
      end
      // Defaults beat a level write in the same cycle, but the wire mode is left
      // alone so a host write to 0x00 that meets the pulse still lands
      if (next_defaults_load) begin
        next_cfg.status_pin_level_select = dcrb_pkg::RST_STATUS_PIN_LEVEL_SELECT;
        next_cfg.host_pin_level_select = dcrb_pkg::RST_HOST_PIN_LEVEL_SELECT;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg.serial_four_wire_select <= dcrb_pkg::RST_SERIAL_FOUR_WIRE_SELECT;
      cfg.status_pin_level_select <= dcrb_pkg::RST_STATUS_PIN_LEVEL_SELECT;
      cfg.host_pin_level_select <= dcrb_pkg::RST_HOST_PIN_LEVEL_SELECT;
    end else begin
      cfg <= next_cfg;
    end
  end

  // ----------------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------------
  // Straps are caught after reset release, never inside the async branch
  // Limitation: a strap that moves shows up one cycle late in the readback
  always_comb begin
    next_por_seen = por_seen | por_done;
    next_strap_hold = {address_strap_upper, address_strap_lower};
    next_spi_mode = interface_select_pin;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      por_seen <= 1'b0;
      strap_hold <= 2'h0;
      spi_mode <= 1'b0;
    end else begin
      por_seen <= next_por_seen;
      strap_hold <= next_strap_hold;
      spi_mode <= next_spi_mode;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  // Unlisted addresses read zero; other blocks own the rest of the map
  // Read data holds between reads so the engine may fetch it late
  always_comb begin
    next_rdata = rdata;
    next_rdata_valid = 1'b0;
    if (rd_req) begin
      next_rdata_valid = 1'b1;
      next_rdata = dcrb_pkg::READ_ZERO;
      case (acc.addr)
        dcrb_pkg::ADDR_DEVICE_CONTROL: begin
          next_rdata[dcrb_pkg::BIT_SERIAL_FOUR_WIRE_SELECT] =
            cfg.serial_four_wire_select;
        end
        dcrb_pkg::ADDR_BUS_ADDRESS_READBACK: begin
          next_rdata[6:2] = dcrb_pkg::BUS_ADDRESS_FIXED;
          if (por_seen && !spi_mode) begin
            next_rdata[1:0] = strap_hold;
          end else begin
            next_rdata[1:0] = 2'h0;
          end
        end
        dcrb_pkg::ADDR_IO_VOLTAGE_SELECT: begin
          next_rdata[dcrb_pkg::BIT_STATUS_PIN_LEVEL_SELECT] = cfg.status_pin_level_select;
          next_rdata[dcrb_pkg::BIT_HOST_PIN_LEVEL_SELECT] = cfg.host_pin_level_select;
        end
        default: begin
          next_rdata = dcrb_pkg::READ_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
      rdata_valid <= 1'b0;
    end else begin
      rdata <= next_rdata;
      rdata_valid <= next_rdata_valid;
    end
  end

  // ----------------------------------------------------------------------
  // Pin steering and registered pin outputs
  // ----------------------------------------------------------------------
  dcrb_pin_steer u_steer (
    .four_wire(cfg.serial_four_wire_select),
    .sdo_bit(sdo_bit),
    .sdo_drive(sdo_drive),
    .sdi_bit(sdi_bit_c),
    .mosi_in(mosi_in),
    .mosi_out(mosi_out_c),
    .mosi_oe(mosi_oe_c),
    .miso_out(miso_out_c),
    .miso_oe(miso_oe_c)
  );

  // Output copies; every top-level port leaves straight from a flop
  always_comb begin
    next_sdi_bit = sdi_bit_c;
    next_mosi_out = mosi_out_c;
    next_mosi_oe = mosi_oe_c;
    next_miso_out = miso_out_c;
    next_miso_oe = miso_oe_c;
    next_serial_four_wire_select = cfg.serial_four_wire_select;
    next_status_pin_level_select = cfg.status_pin_level_select;
    next_host_pin_level_select = cfg.host_pin_level_select;
  end

  // Registering adds one cycle of pin latency, well inside the serial bit time
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sdi_bit <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      serial_four_wire_select <= dcrb_pkg::RST_SERIAL_FOUR_WIRE_SELECT;
      status_pin_level_select <= dcrb_pkg::RST_STATUS_PIN_LEVEL_SELECT;
      host_pin_level_select <= dcrb_pkg::RST_HOST_PIN_LEVEL_SELECT;
    end else begin
      sdi_bit <= next_sdi_bit;
      mosi_out <= next_mosi_out;
      mosi_oe <= next_mosi_oe;
      miso_out <= next_miso_out;
      miso_oe <= next_miso_oe;
      serial_four_wire_select <= next_serial_four_wire_select;
      status_pin_level_select <= next_status_pin_level_select;
      host_pin_level_select <= next_host_pin_level_select;
    end
  end

endmodule
`default_nettype wire

// File: logic/dcrb_pin_steer.sv
// Purpose: Routes serial data between the three-wire and four-wire pin plans.
// Assumes: Serial engine supplies its output bit and a drive request.
// Notes: Pure steering, all outputs registered by the caller's clock.
`timescale 1ns/1ps
`default_nettype none
module dcrb_pin_steer (
  // Mode
  input wire logic four_wire,
  // Serial engine side
  input wire logic sdo_bit,
  input wire logic sdo_drive,
  output logic sdi_bit,
  // Pins
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  output logic miso_out,
  output logic miso_oe
);

  // Three-wire shares MOSI both ways, four-wire splits the directions
  always_comb begin
    sdi_bit = mosi_in;
    mosi_out = four_wire ? 1'b0 : sdo_bit;
    mosi_oe = four_wire ? 1'b0 : sdo_drive;
    miso_out = four_wire ? sdo_bit : 1'b0;
    miso_oe = four_wire ? sdo_drive : 1'b0;
  end

endmodule
`default_nettype wire

// File: logic/dcrb_pkg.sv
// Purpose: Shared constants and types for the device configuration register bank.
// Assumes: Registers are byte wide at the printed addresses of a 7-bit space.
// Notes: Register offsets, control and level field positions and configuration reset values live here.
package dcrb_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [6:0] ADDR_DEVICE_CONTROL = 7'h00;
  localparam logic [6:0] ADDR_BUS_ADDRESS_READBACK = 7'h01;
  localparam logic [6:0] ADDR_IO_VOLTAGE_SELECT = 7'h1F;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BIT_SOFT_REGISTER_RESET = 0;
  localparam int BIT_SERIAL_FOUR_WIRE_SELECT = 1;
  localparam int BIT_HOST_PIN_LEVEL_SELECT = 0;
  localparam int BIT_STATUS_PIN_LEVEL_SELECT = 1;

  // ----------------------------------------------------------------------
  // Reset values and fixed patterns
  // ----------------------------------------------------------------------
  localparam logic RST_SERIAL_FOUR_WIRE_SELECT = 1'h0;
  localparam logic RST_STATUS_PIN_LEVEL_SELECT = 1'h1;
  localparam logic RST_HOST_PIN_LEVEL_SELECT = 1'h0;
  localparam logic [4:0] BUS_ADDRESS_FIXED = 5'h1B;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  // Register access request from the serial engine
  typedef struct packed {
    logic wr_en;
    logic [6:0] addr;
    logic [7:0] wdata;
  } dcrb_access_type;

  // Configuration held in the bank
  typedef struct packed {
    logic serial_four_wire_select;
    logic status_pin_level_select;
    logic host_pin_level_select;
  } dcrb_config_type;

  // Sequencer for the soft reset pulse
  typedef enum logic [2:0] {
    SR_IDLE = 3'h1,
    SR_PULSE = 3'h2,
    SR_CLEAR = 3'h4
  } dcrb_soft_reset_state_type;

endpackage

// File: sim/dcrb_checker.sv
// Purpose: Port assertions for the register bank.
// Assumes: One clock, async active-high reset.
// Notes: Lags follow the hand-over timing.
`timescale 1ns/1ps
`default_nettype none
module dcrb_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Access side
  input wire logic acc_req,
  input wire dcrb_pkg::dcrb_access_type acc,
  input wire logic [7:0] rdata,
  input wire logic rdata_valid,
  input wire logic interface_select_pin,
  // Pin side
  input wire logic sdo_bit,
  input wire logic sdo_drive,
  input wire logic mosi_oe,
  input wire logic miso_out,
  input wire logic miso_oe,
  // Configuration
  input wire logic serial_four_wire_select,
  input wire logic status_pin_level_select,
  input wire logic host_pin_level_select,
  input wire logic defaults_load
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  a_read_answer: assert property (acc_req && !acc.wr_en |=> rdata_valid)
    else $error("read not answered");
  a_fixed_pattern: assert property (rdata_valid && $past(acc.addr) == 7'h01 |->
    rdata[7:2] == 6'h1B) else $error("address pattern wrong");
  a_spi_straps: assert property (rdata_valid && $past(acc.addr) == 7'h01 &&
    $past(interface_select_pin) && $past(interface_select_pin, 2) |-> rdata[1:0] == 2'h0)
    else $error("strap bits shown in SPI mode");
  a_reserved_zero: assert property (rdata_valid && $past(acc.addr) == 7'h00 |->
    rdata[7:2] == 6'h00 && !rdata[0]) else $error("reserved bits not zero");
  a_three_wire: assert property (!serial_four_wire_select && !$past(serial_four_wire_select)
    |-> !miso_oe && mosi_oe == $past(sdo_drive)) else $error("three wire pins wrong");
  a_four_wire: assert property (serial_four_wire_select && $past(serial_four_wire_select)
    |-> !mosi_oe && miso_oe == $past(sdo_drive) && (!miso_oe || miso_out == $past(sdo_bit)))
    else $error("four wire pins wrong");
  a_soft_reset_pulse: assert property (acc_req && acc.wr_en && acc.addr == 7'h00 &&
    acc.wdata[0] |-> ##[2:3] defaults_load) else $error("no defaults pulse");
  a_pulse_single: assert property (defaults_load |=> !defaults_load)
    else $error("defaults pulse too long");
  a_level_write: assert property (acc_req && acc.wr_en && acc.addr == 7'h1F |-> ##2
    status_pin_level_select == $past(acc.wdata[1], 2) &&
    host_pin_level_select == $past(acc.wdata[0], 2)) else $error("level bits wrong");
endmodule
bind dcrb_bank dcrb_checker u_chk (.sys_clk(sys_clk), .rst(rst), .acc_req(acc_req),
  .acc(acc), .rdata(rdata), .rdata_valid(rdata_valid),
  .interface_select_pin(interface_select_pin), .sdo_bit(sdo_bit), .sdo_drive(sdo_drive),
  .mosi_oe(mosi_oe), .miso_out(miso_out), .miso_oe(miso_oe),
  .serial_four_wire_select(serial_four_wire_select),
  .status_pin_level_select(status_pin_level_select),
  .host_pin_level_select(host_pin_level_select), .defaults_load(defaults_load));
`default_nettype wire

// File: sim/dcrb_host_model.sv
// Purpose: Host side that issues byte accesses to the bank.
// Assumes: One access per call, taken on a rising edge.
// Notes: Stale write data is inverted once the access is over.
`timescale 1ns/1ps
`default_nettype none
module dcrb_host_model (
  // Clock
  input wire logic sys_clk,
  // Access to the bank
  output logic acc_req,
  output dcrb_pkg::dcrb_access_type acc
);
  // ----
  // Access
  // ----
  // Idle until the first call
  initial begin
    acc_req = 1'b0;
    acc = '0;
  end
  // Request held across the taking edge, then released
  task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    acc_req = 1'b1;
    acc = '{wr_en: wr, addr: a, wdata: d};
    @(posedge sys_clk);
    #1;
    acc_req = 1'b0;
    acc.wdata = ~d; // Data is stale now
  endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
// Purpose: Self-checking bench for the register bank.
// Assumes: Lags as in the hand-over timing.
// Notes: Model holds {four wire, status level, host level}.
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ----
  // Signals
  // ----
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic por_done = 1'b0;
  logic nv_load = 1'b0;
  dcrb_pkg::dcrb_config_type nv_config = '0;
  logic [1:0] strap = 2'h0;
  logic isel = 1'b0;
  logic sdo_bit = 1'b0;
  logic sdo_drive = 1'b0;
  logic mosi_in = 1'b0;
  logic acc_req;
  dcrb_pkg::dcrb_access_type acc;
  logic [7:0] rdata;
  logic rdata_valid, sdi_bit, mosi_out, mosi_oe, miso_out, miso_oe, fw, sl, hl, dl;
  int mismatches = 0;
  int n_tests = 0;
  int n_dl = 0;
  logic [31:0] lfsr = 32'hB60F42FA;
  logic [2:0] m_cfg = 3'h2;
  // Clock and pulse count
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (dl === 1'b1) n_dl++;
  dcrb_host_model h (.sys_clk(sys_clk), .acc_req(acc_req), .acc(acc));
  dcrb_bank DUT (.sys_clk(sys_clk), .rst(rst), .por_done(por_done), .nv_load(nv_load),
    .nv_config(nv_config), .acc_req(acc_req), .acc(acc), .rdata(rdata),
    .rdata_valid(rdata_valid), .address_strap_upper(strap[1]),
    .address_strap_lower(strap[0]), .interface_select_pin(isel), .sdo_bit(sdo_bit),
    .sdo_drive(sdo_drive), .sdi_bit(sdi_bit), .mosi_in(mosi_in), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_out(miso_out), .miso_oe(miso_oe),
    .serial_four_wire_select(fw), .status_pin_level_select(sl),
    .host_pin_level_select(hl), .defaults_load(dl));
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Model read value; strap bits only in bus mode after power-up
  function automatic logic [7:0] exp_rd(input logic [6:0] a);
    case (a)
      7'h00: return {6'h00, m_cfg[2], 1'b0};
      7'h01: return {6'h1B, (por_done && !isel) ? strap : 2'h0};
      7'h1F: return {6'h00, m_cfg[1:0]};
      default: return 8'h00;
    endcase
  endfunction
  // Next value of the stimulus shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic rd(input logic [6:0] a);
    logic [7:0] e;
    e = exp_rd(a);
    h.xfer(1'b0, a, 8'h00);
    chk(rdata, e);
    chk({7'h0, rdata_valid}, 8'h01);
  endtask
  // Write and track; a soft reset restores the level defaults
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    h.xfer(1'b1, a, d);
    if (a == 7'h1F) m_cfg[1:0] = d[1:0];
    if (a == 7'h00) m_cfg[2] = d[1];
    if (a == 7'h00 && d[0]) m_cfg[1:0] = 2'h2;
  endtask
  task automatic cfgp();
    repeat (3) @(posedge sys_clk);
    #1;
    chk({5'h0, fw, sl, hl}, {5'h0, m_cfg});
  endtask
  // Random pin traffic, one cycle
  task automatic pins();
    logic [2:0] r;
    lfsr = lfsr_next(lfsr);
    r = lfsr[2:0];
    {sdo_bit, sdo_drive, mosi_in} = r;
    @(posedge sys_clk);
    #1;
    chk({6'h0, mosi_oe, miso_oe}, {6'h0, !m_cfg[2] && r[1], m_cfg[2] && r[1]});
    chk({6'h0, sdi_bit, r[1] && (m_cfg[2] ? miso_out : mosi_out)}, {6'h0, r[0], r[1] && r[2]});
  endtask
  // Watchdog
  initial begin
    #20000;
    mismatches++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    cfgp();
    rd(7'h00);
    strap = 2'h3;
    rd(7'h01);
    por_done = 1'b1;
    for (int i = 0; i < 4; i++) begin
      strap = i[1:0];
      rd(7'h01);
    end
    isel = 1'b1;
    rd(7'h01);
    isel = 1'b0;
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      wr(7'h1F, lfsr[7:0]);
      rd(7'h1F);
      cfgp();
    end
    for (int m = 0; m < 2; m++) begin
      wr(7'h00, (m == 1) ? 8'hFE : 8'h00);
      cfgp();
      repeat (8) pins();
    end
    wr(7'h1F, 8'h01);
    n_dl = 0;
    wr(7'h00, 8'h03);
    cfgp();
    rd(7'h00);
    rd(7'h1F);
    rd(7'h01);
    chk(n_dl[7:0], 8'h01);
    nv_config = 3'h5;
    nv_load = 1'b1;
    m_cfg = 3'h5;
    @(posedge sys_clk);
    #1;
    nv_load = 1'b0;
    cfgp();
    rd(7'h5A);
    report_and_stop();
  end
endmodule
`default_nettype wire
